// ---- rx_sig_pkg.sv ----
package rx_sig_pkg;
  // Channel and multiframe geometry
  localparam int          NUM_CH        = 24;
  localparam logic [4:0]  LAST_CH       = 5'h17;
  localparam logic [4:0]  SF_LAST_FRAME = 5'h0C;
  localparam logic [4:0]  ESF_LAST_FRM  = 5'h18;
  localparam logic [4:0]  FIRST_FRAME   = 5'h01;
  localparam logic [4:0]  FRM_A         = 5'h06;
  localparam logic [4:0]  FRM_B         = 5'h0C;
  localparam logic [4:0]  FRM_C         = 5'h12;
  localparam logic [4:0]  FRM_D         = 5'h18;

  // Line formats seen on the fmt input
  localparam logic [1:0]  FMT_SF        = 2'h0;
  localparam logic [1:0]  FMT_ESF       = 2'h1;
  localparam logic [1:0]  FMT_SLC96     = 2'h2;

  // Direct register offsets
  localparam logic [7:0]  OFS_PAY_CFG   = 8'hD0;
  localparam logic [7:0]  OFS_PAY_EN    = 8'hD1;
  localparam logic [7:0]  OFS_SIG_CFG   = 8'hD2;
  localparam logic [7:0]  OFS_ACC_STAT  = 8'hD3;
  localparam logic [7:0]  OFS_ACC_CTRL  = 8'hD4;
  localparam logic [7:0]  OFS_ACC_DATA  = 8'hD5;
  localparam logic [7:0]  OFS_FLAGS0    = 8'hD6;
  localparam logic [7:0]  OFS_FLAGS1    = 8'hD7;
  localparam logic [7:0]  OFS_FLAGS2    = 8'hD8;

  // Field positions, payload configuration
  localparam int          B_SNAP        = 7;
  localparam int          B_GTRUNK      = 6;
  // Field positions, payload control enable
  localparam int          B_POS_SEL     = 3;
  localparam int          B_FORCE_EN    = 2;
  localparam int          B_FORCE_LVL   = 1;
  localparam int          B_MASTER_EN   = 0;
  // Field positions, signaling configuration
  localparam int          B_FREEZE      = 3;
  localparam int          B_DEB         = 2;
  localparam int          B_IRQ_EN      = 1;
  localparam int          B_SIG_FMT     = 0;
  // Field positions, access control and indirect data
  localparam int          B_DIR         = 7;
  localparam int          B_EXT_EN      = 4;

  // Reset values
  localparam logic [7:0]  RST_PAY_CFG   = 8'h80;
  localparam logic [7:0]  RST_PAY_EN    = 8'h00;
  localparam logic [7:0]  RST_SIG_CFG   = 8'h01;
  localparam logic [7:0]  RST_ACC       = 8'h00;

  // Indirect address window
  localparam logic [6:0]  IND_FIRST     = 7'h01;
  localparam logic [6:0]  IND_LAST      = 7'h18;

  // Substitution selections
  localparam logic [2:0]  SUB_NONE      = 3'h0;
  localparam logic [2:0]  SUB_TRUNK     = 3'h1;
  localparam logic [2:0]  SUB_ALAW      = 3'h2;
  localparam logic [2:0]  SUB_MULAW     = 3'h3;

  // Digital milliwatt sequences, eight bytes each
  localparam logic [0:7][7:0] MW_ALAW  = {8'h34, 8'h21, 8'h21, 8'h34,
                                          8'hB4, 8'hA1, 8'hA1, 8'hB4};
  localparam logic [0:7][7:0] MW_MULAW = {8'h1E, 8'h0B, 8'h0B, 8'h1E,
                                          8'h9E, 8'h8B, 8'h8B, 8'h9E};
endpackage

// ---- rx_payload_signaling_ctrl.sv ----
// How it works
// - Snapshot holds first-frame signaling whole superframe
// - Trunk conditioning per channel or global
// - Global select zero uses per-channel substitution
// - Global select one applies data trunk code
// - Codes two/three give A-law/mu-law milliwatt
// - Signaling force only in SF/ESF/SLC-96
// - Force level picks logic zero or one
// - Master enable gates all payload functions
// - Freeze holds stored ABCD values
// - Debounce needs two matching codewords
// - Interrupt when enabled and any flag
// - Four-state: frames 6/18 A, 12/24 B
// - Sixteen-state stores all four bits in ESF/SLC-96
// - Position option keeps only upper two bits
// - Busy shows during indirect access
// - Control holds direction and seven-bit address
// - Read command returns byte in data
// - Change flags per channel, three registers
// - Writing one clears a flag
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module rx_payload_signaling_ctrl (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Framer side receive stream, one byte per channel slot
  input  wire logic                  rx_valid,
  input  wire logic [4:0]            rx_chan,
  input  wire logic [4:0]            rx_frame,
  input  wire logic [7:0]            rx_data,
  input  wire logic [1:0]            rx_fmt,
  input  wire logic                  rx_mf_sync,
  // Per-channel settings presented with each slot
  input  wire logic [2:0]            channel_substitution_sel,
  input  wire logic [7:0]            data_trunk_code,
  input  wire logic                  channel_trunk_cond_en,
  input  wire logic [3:0]            trunk_cond_code,
  // System side receive output
  output logic                       rx_out_valid,
  output logic      [7:0]            rx_out_data,
  output logic      [3:0]            rx_signaling_out,
  output logic                       irq
);
  import rx_sig_pkg::*;

  // Whole module state
  // One struct, so every flop shares one reset
  typedef struct packed {
    logic [7:0]             pay_cfg;     // Snapshot, trunk, substitution
    logic [7:0]             pay_en;      // Position, force, master
    logic [7:0]             sig_cfg;     // Freeze, debounce, irq, format
    logic [7:0]             acc_ctrl;    // Direction and address
    logic [7:0]             acc_data;    // Indirect data byte
    logic                   busy;        // Indirect access pending
    logic [23:0]            flags;       // Change of state per channel
    logic [23:0]            ext_en;      // Extraction enable per channel
    logic [23:0][3:0]       abcd;        // Stored signaling
    logic [23:0][3:0]       asm_cw;      // Codeword being assembled
    logic [23:0][3:0]       prev_cw;     // Last received codeword
    logic [23:0][3:0]       snap;        // Snapshot copies
    logic [2:0]             mw_phase;    // Milliwatt byte index
    logic [7:0]             rdata;       // Read data register
    logic                   irq;         // Interrupt output
    logic                   out_valid;   // Output strobe
    logic [7:0]             out_data;    // Output payload
    logic [3:0]             out_sig;     // Output signaling
  } state_t;

  state_t st_r;   // Registered state
  state_t st_nxt; // Next state

  // Decoded configuration
  logic       snap_en;
  logic       gtrunk_en;
  logic [2:0] gsub_sel;
  logic       pos_sel;
  logic       force_en;
  logic       force_lvl;
  logic       master_en;
  logic       freeze_en;
  logic       deb_en;
  logic       irq_en;
  logic       sig_16;
  // Stream helpers
  logic       sig_fmt;     // Format carries robbed-bit signaling
  logic       esf_like;    // ESF or SLC-96
  logic       chan_ok;     // Slot index in range
  logic [4:0] mf_last;     // Last frame of multiframe
  logic [3:0] cw;          // Codeword with this slot's bit merged
  logic [3:0] cw_masked;   // Codeword after format masking
  logic       accept;      // Codeword may update storage
  logic [2:0] sub_sel;     // Effective substitution
  logic [3:0] sig_src;     // Signaling before conditioning
  logic [4:0] ind_idx;     // Indirect channel index
  logic       ind_ok;      // Indirect address in window
  logic [23:0] clr_mask;   // Flags cleared by this write
  logic [23:0] set_mask;   // Flags set by this slot

  // Field decode from the held registers
  assign snap_en   = st_r.pay_cfg[B_SNAP];
  assign gtrunk_en = st_r.pay_cfg[B_GTRUNK];
  assign gsub_sel  = st_r.pay_cfg[2:0];
  assign pos_sel   = st_r.pay_en[B_POS_SEL];
  assign force_en  = st_r.pay_en[B_FORCE_EN];
  assign force_lvl = st_r.pay_en[B_FORCE_LVL];
  assign master_en = st_r.pay_en[B_MASTER_EN];
  assign freeze_en = st_r.sig_cfg[B_FREEZE];
  assign deb_en    = st_r.sig_cfg[B_DEB];
  assign irq_en    = st_r.sig_cfg[B_IRQ_EN];
  assign sig_16    = st_r.sig_cfg[B_SIG_FMT];

  // Format and window decode
  // Slot index past 23 is refused, not wrapped
  assign esf_like = (rx_fmt == FMT_ESF) || (rx_fmt == FMT_SLC96);
  assign sig_fmt  = esf_like || (rx_fmt == FMT_SF);
  assign chan_ok  = (rx_chan <= LAST_CH);
  assign mf_last  = esf_like ? ESF_LAST_FRM : SF_LAST_FRAME;
  assign ind_ok   = (st_r.acc_ctrl[6:0] >= IND_FIRST) &&
                    (st_r.acc_ctrl[6:0] <= IND_LAST);
  assign ind_idx  = 5'(st_r.acc_ctrl[6:0] - IND_FIRST);

  // Merge this slot's robbed bit into the channel codeword
  // Only bit 0 of the slot byte is signaling
  always_comb begin
    // Out-of-range slot reads no storage
    cw = chan_ok ? st_r.asm_cw[rx_chan] : 4'h0;
    if (esf_like && !sig_16) begin
      if (rx_frame == FRM_A || rx_frame == FRM_C) begin
        cw[3] = rx_data[0];
      end
      if (rx_frame == FRM_B || rx_frame == FRM_D) begin
        cw[2] = rx_data[0];
      end
    end else begin
      // sixteen-state, SF uses A and B only
      if (rx_frame == FRM_A) begin
        cw[3] = rx_data[0];
      end
      if (rx_frame == FRM_B) begin
        cw[2] = rx_data[0];
      end
      if (rx_frame == FRM_C) begin
        cw[1] = rx_data[0];
      end
      if (rx_frame == FRM_D) begin
        cw[0] = rx_data[0];
      end
    end
  end

  // Drop bits the current format does not carry
  always_comb begin
    // C and D also dropped in SF and four-state
    cw_masked = cw;
    // only A and B valid with position option
    if (!esf_like || !sig_16 || pos_sel) begin
      cw_masked[1:0] = 2'h0;
    end
  end

  // Whether a finished codeword may reach storage
  always_comb begin
    accept = !freeze_en;
    // Previous codeword tracks even while frozen
    // debounce wants two equal codewords
    if (deb_en && chan_ok && (cw_masked != st_r.prev_cw[rx_chan])) begin
      accept = 1'b0;
    end
  end

  // Effective data substitution for this slot
  // Per-slot field counts only when global is zero
  always_comb begin
    // per-channel field when global is zero
    sub_sel = (gsub_sel == SUB_NONE) ? channel_substitution_sel : gsub_sel;
    // Codes four to seven fall through as data
  end

  // Signaling source before trunk and force
  always_comb begin
    // Frame one shows stored value and arms copy
    sig_src = 4'h0;
    if (chan_ok) begin
      if (master_en && snap_en && rx_mf_sync && sig_fmt) begin
        sig_src = (rx_frame == FIRST_FRAME) ? st_r.abcd[rx_chan]
                                            : st_r.snap[rx_chan];
      end else begin
        sig_src = st_r.abcd[rx_chan];
      end
    end
  end

  // Flag masks: set by extraction, cleared by write-one
  always_comb begin
    clr_mask = 24'h00_0000;
    set_mask = 24'h00_0000;
    // Only the three flag offsets clear
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_FLAGS0: clr_mask[7:0]   = reg_wdata;
        OFS_FLAGS1: clr_mask[15:8]  = reg_wdata;
        OFS_FLAGS2: clr_mask[23:16] = reg_wdata;
        default:    clr_mask        = 24'h00_0000;
      endcase
    end
    // Flag only when the stored value changes
    if (rx_valid && chan_ok && rx_mf_sync && sig_fmt &&
        st_r.ext_en[rx_chan] && (rx_frame == mf_last) && accept &&
        (cw_masked != st_r.abcd[rx_chan])) begin
      set_mask[rx_chan] = 1'b1;
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.out_valid = 1'b0;
    // Read data falls back to zero each cycle
    st_nxt.rdata     = 8'h00;

    // Register writes
    // Reserved bits masked so they read back zero
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_PAY_CFG: st_nxt.pay_cfg = reg_wdata & 8'hC7;
        OFS_PAY_EN:  st_nxt.pay_en  = reg_wdata & 8'h0F;
        OFS_SIG_CFG: st_nxt.sig_cfg = reg_wdata & 8'h0F;
        OFS_ACC_CTRL: begin
          // a command arms busy; ignored while busy
          if (!st_r.busy) begin
            st_nxt.acc_ctrl = reg_wdata;
            st_nxt.busy     = 1'b1;
          end
        end
        OFS_ACC_DATA: begin
          // data staged before the write command
          if (!st_r.busy) begin
            st_nxt.acc_data = reg_wdata;
          end
        end
        default: begin
          // Other offsets store nothing
          // Unmapped writes leave no trace
        end
      endcase
    end

    // Register reads, data in next cycle
    // Reading never disturbs flags or busy
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_PAY_CFG:  st_nxt.rdata = st_r.pay_cfg;
        OFS_PAY_EN:   st_nxt.rdata = st_r.pay_en;
        OFS_SIG_CFG:  st_nxt.rdata = st_r.sig_cfg;
        OFS_ACC_STAT: st_nxt.rdata = {7'h00, st_r.busy};
        OFS_ACC_CTRL: st_nxt.rdata = st_r.acc_ctrl;
        OFS_ACC_DATA: st_nxt.rdata = st_r.acc_data;
        OFS_FLAGS0:   st_nxt.rdata = st_r.flags[7:0];
        OFS_FLAGS1:   st_nxt.rdata = st_r.flags[15:8];
        OFS_FLAGS2:   st_nxt.rdata = st_r.flags[23:16];
        default:      st_nxt.rdata = 8'h00;
      endcase
    end

    // Indirect access completes one cycle after the command
    // A status read in the next cycle still shows busy; the read after shows it clear
    if (st_r.busy) begin
      st_nxt.busy = 1'b0;
      if (ind_ok) begin
        if (st_r.acc_ctrl[B_DIR]) begin
          st_nxt.acc_data = {3'h0, st_r.ext_en[ind_idx],
                             st_r.abcd[ind_idx]};
        end else begin
          st_nxt.ext_en[ind_idx] = st_r.acc_data[B_EXT_EN];
        end
      end else if (st_r.acc_ctrl[B_DIR]) begin
        // Out-of-window read returns zero
        st_nxt.acc_data = 8'h00;
      end
    end

    // Receive slot processing
    // Extraction itself ignores master enable
    if (rx_valid && chan_ok) begin
      // Assemble codeword; restart at first frame
      st_nxt.asm_cw[rx_chan] = (rx_frame == FIRST_FRAME) ? 4'h0 : cw;
      // lock first-frame signaling for the superframe
      if (rx_frame == FIRST_FRAME) begin
        st_nxt.snap[rx_chan] = st_r.abcd[rx_chan];
      end
      // Codeword complete at multiframe end
      if (rx_mf_sync && sig_fmt && st_r.ext_en[rx_chan] &&
          (rx_frame == mf_last)) begin
        st_nxt.prev_cw[rx_chan] = cw_masked;
        if (accept) begin
          st_nxt.abcd[rx_chan] = cw_masked;
        end
      end
      // Milliwatt sequence advances once per frame
      // Three-bit phase wraps every eight frames
      if (rx_chan == LAST_CH) begin
        st_nxt.mw_phase = st_r.mw_phase + 3'h1;
      end

      // Output payload
      // Pass-through unless a function below acts
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data  = rx_data;
      st_nxt.out_sig   = sig_src;
      if (master_en) begin
        unique case (sub_sel)
          // data trunk code, by global or per-channel select
          SUB_TRUNK: st_nxt.out_data = data_trunk_code;
          SUB_ALAW:  st_nxt.out_data = MW_ALAW[st_r.mw_phase];
          SUB_MULAW: st_nxt.out_data = MW_MULAW[st_r.mw_phase];
          default:   st_nxt.out_data = rx_data;
        endcase
        // trunk conditioning global or per channel
        if (gtrunk_en || channel_trunk_cond_en) begin
          st_nxt.out_sig = trunk_cond_code;
        end
        // Force last, so it wins over trunk code
        // force only in signaling formats
        if (force_en && sig_fmt) begin
          st_nxt.out_sig = force_lvl ? 4'hF : 4'h0;
        end
      end
    end

    // set wins over a same-cycle clear
    st_nxt.flags = (st_r.flags & ~clr_mask) | set_mask;
    // Registered from next flags, so irq changes in the same cycle as flags
    // interrupt from any flag when enabled
    st_nxt.irq = irq_en && (|st_nxt.flags);
  end

  // State register
  // Reset branch loads constants only
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r          <= '0;
      st_r.pay_cfg  <= RST_PAY_CFG;
      st_r.pay_en   <= RST_PAY_EN;
      st_r.sig_cfg  <= RST_SIG_CFG;
      st_r.acc_ctrl <= RST_ACC;
      st_r.acc_data <= RST_ACC;
      // Every channel extracts after reset
      st_r.ext_en   <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state flops
  // No logic after the flops, so no glitches
  assign reg_rdata        = st_r.rdata;
  assign rx_out_valid     = st_r.out_valid;
  assign rx_out_data      = st_r.out_data;
  assign rx_signaling_out = st_r.out_sig;
  assign irq              = st_r.irq;
endmodule

// ---- rx_payload_signaling_ctrl_assertions.sv ----
`timescale 1ns/10ps
module rx_payload_signaling_ctrl_chk (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_valid,
  input wire logic [4:0] rx_chan,
  input wire logic [7:0] rx_data,
  input wire logic [1:0] rx_fmt,
  input wire logic [7:0] data_trunk_code,
  input wire logic       rx_out_valid,
  input wire logic [7:0] rx_out_data,
  input wire logic [3:0] rx_signaling_out,
  input wire logic       irq
);
  import rx_sig_pkg::*;
  logic [7:0] cfg_r;     // Shadow of payload configuration
  logic [7:0] en_r;      // Shadow of payload control enable
  logic [7:0] sig_r;     // Shadow of signaling configuration
  logic       acc_wr_r;  // Access control written last cycle
  wire        slot   = rx_valid && (rx_chan <= LAST_CH);
  wire        acc_wr = reg_wr && (reg_addr == OFS_ACC_CTRL);
  // Shadows follow host writes, so checks see the live settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_r    <= RST_PAY_CFG;
      en_r     <= RST_PAY_EN;
      sig_r    <= RST_SIG_CFG;
      acc_wr_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_PAY_CFG) cfg_r <= reg_wdata;
      if (reg_wr && reg_addr == OFS_PAY_EN) en_r <= reg_wdata;
      if (reg_wr && reg_addr == OFS_SIG_CFG) sig_r <= reg_wdata;
      acc_wr_r <= acc_wr;
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_slot_answer: assert property (slot |=> rx_out_valid)
    else $error("channel slot gave no output");
  a_no_stray_out: assert property (!slot |=> !rx_out_valid)
    else $error("output without a channel slot");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  a_enable_readback: assert property (reg_rd && reg_addr == OFS_PAY_EN
    |=> reg_rdata == (en_r & 8'h0F)) else $error("enable readback wrong");
  a_busy_shown: assert property (!acc_wr_r && acc_wr ##1 reg_rd
    && reg_addr == OFS_ACC_STAT |=> reg_rdata == 8'h01)
    else $error("busy not shown after access");
  a_busy_ends: assert property (acc_wr ##1 !reg_wr ##1 reg_rd
    && reg_addr == OFS_ACC_STAT |=> reg_rdata == 8'h00)
    else $error("busy held too long");
  a_master_off: assert property (slot && !en_r[B_MASTER_EN]
    |=> rx_out_data == $past(rx_data)) else $error("data altered when off");
  a_trunk_all: assert property (slot && en_r[B_MASTER_EN]
    && cfg_r[2:0] == SUB_TRUNK |=> rx_out_data == $past(data_trunk_code))
    else $error("data trunk code not applied");
  a_force_level: assert property (slot && en_r[B_MASTER_EN]
    && en_r[B_FORCE_EN] && rx_fmt != 2'h3
    |=> rx_signaling_out == {4{$past(en_r[B_FORCE_LVL])}})
    else $error("forced signaling level wrong");
  a_irq_gated: assert property (!sig_r[B_IRQ_EN] |=> !irq)
    else $error("interrupt while disabled");
  c_alaw: cover property (slot && en_r[B_MASTER_EN] && cfg_r[2:0] == SUB_ALAW);
  c_irq: cover property (irq);
  c_access: cover property (acc_wr);
endmodule
bind rx_payload_signaling_ctrl rx_payload_signaling_ctrl_chk chk_u (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_chan(rx_chan),
  .rx_data(rx_data), .rx_fmt(rx_fmt), .data_trunk_code(data_trunk_code),
  .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
  .rx_signaling_out(rx_signaling_out), .irq(irq));

// ---- framer_model.sv ----
`timescale 1ns/10ps
module framer_model (
  input  wire logic       clk_sys,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic [3:0] abcd,
  output logic            rx_valid,
  output logic [4:0]      rx_chan,
  output logic [4:0]      rx_frame,
  output logic [7:0]      rx_data,
  output logic            busy
);
  // Robbed bit of frame f: A, B, C, D on frames 6, 12, 18, 24
  function automatic logic sbit(input int f, input logic [3:0] s);
    return (f == 6) ? s[3] : (f == 12) ? s[2] : (f == 18) ? s[1] :
           (f == 24) ? s[0] : 1'b0;
  endfunction
  initial begin
    rx_valid = 1'b0;
    rx_chan  = 5'h1F;
    rx_frame = 5'h00;
    rx_data  = 8'h00;
    busy     = 1'b0;
  end
  // One whole 24-frame multiframe per go pulse
  always @(posedge clk_sys) begin
    if (go) begin
      busy <= 1'b1;
      for (int f = 1; f <= 24; f++) begin
        for (int c = 0; c < 24; c++) begin
          rx_valid <= 1'b1;
          rx_chan  <= 5'(c);
          rx_frame <= 5'(f);
          rx_data  <= {3'(c), 4'(f), sbit(f, abcd)};
          @(posedge clk_sys);
          // Slow mode idles a cycle; the data line then shows garbage
          if (slow) begin
            rx_valid <= 1'b0;
            rx_data  <= ~rx_data;
            @(posedge clk_sys);
          end
        end
      end
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      busy     <= 1'b0;
    end
  end
endmodule

// ---- test_rx_payload_signaling_ctrl.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module test_rx_payload_signaling_ctrl;
  import rx_sig_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [1:0] rx_fmt = FMT_ESF;
  logic       rx_mf_sync = 1'b1;
  logic [2:0] sub_sel = SUB_TRUNK;   // Per-slot substitution field
  logic [7:0] trunk_byte = 8'h5C;    // Per-slot data trunk code
  logic       cond_en = 1'b0;        // Per-slot trunk conditioning
  logic [3:0] cond_code = 4'h6;
  logic       go = 1'b0;             // Framer start, one multiframe
  logic       slow = 1'b0;
  logic [3:0] abcd = 4'h0;
  logic [7:0] reg_rdata, rx_data, rx_out_data;
  logic [4:0] rx_chan, rx_frame;
  logic [3:0] rx_signaling_out;
  logic       rx_valid, rx_out_valid, irq, fbusy;
  logic [7:0] od [576];              // Output bytes by slot index
  logic [3:0] os [576];              // Output signaling by slot index
  int         k = 0;
  int         n_mismatch = 0;
  int         n_compared = 0;
  always #25 clk_sys = ~clk_sys;
  rx_payload_signaling_ctrl dut_u (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_chan(rx_chan), .rx_frame(rx_frame), .rx_data(rx_data),
    .rx_fmt(rx_fmt), .rx_mf_sync(rx_mf_sync),
    .channel_substitution_sel(sub_sel), .data_trunk_code(trunk_byte),
    .channel_trunk_cond_en(cond_en), .trunk_cond_code(cond_code),
    .rx_out_valid(rx_out_valid), .rx_out_data(rx_out_data),
    .rx_signaling_out(rx_signaling_out), .irq(irq));
  framer_model fm_u (.clk_sys(clk_sys), .go(go), .slow(slow), .abcd(abcd),
    .rx_valid(rx_valid), .rx_chan(rx_chan), .rx_frame(rx_frame),
    .rx_data(rx_data), .busy(fbusy));
  // Capture every output slot in arrival order
  always @(posedge clk_sys) begin
    if (rx_out_valid) begin
      od[k] <= rx_out_data;
      os[k] <= rx_signaling_out;
      k     <= k + 1;
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read answer stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, reg_rdata)
  endtask
  // Indirect read: command, one busy cycle, then the data register
  task automatic iread(input logic [6:0] ch, input logic [7:0] e);
    wr(OFS_ACC_CTRL, {1'b1, ch});
    @(posedge clk_sys);
    #1;
    rchk(OFS_ACC_DATA, e);
  endtask
  task automatic clr();
    wr(OFS_FLAGS0, 8'hFF);
    wr(OFS_FLAGS1, 8'hFF);
    wr(OFS_FLAGS2, 8'hFF);
  endtask
  // Bounded wait on the framer; output of the last slot lands after
  task automatic send(input logic [3:0] s, input logic sl);
    abcd <= s;
    slow <= sl;
    go   <= 1'b1;
    k = 0;
    @(posedge clk_sys);
    go <= 1'b0;
    repeat (1300) begin
      @(posedge clk_sys);
      if (!fbusy) break;
    end
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 9; i++) begin
      rchk(OFS_PAY_CFG + 8'(i), (i == 0) ? RST_PAY_CFG :
           (i == 2) ? RST_SIG_CFG : RST_ACC);
    end
    wr(OFS_PAY_EN, 8'hFF);
    rchk(OFS_PAY_EN, 8'h0F);
    wr(OFS_PAY_CFG, 8'hFF);
    rchk(OFS_PAY_CFG, 8'hC7);
    wr(OFS_PAY_EN, 8'h00);
    wr(OFS_PAY_CFG, 8'h00);
    wr(8'hC0, 8'hFF);
    rchk(8'hC0, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_extract();
    send(4'hA, 1'b0);
    rchk(OFS_FLAGS0, 8'hFF);
    rchk(OFS_FLAGS1, 8'hFF);
    rchk(OFS_FLAGS2, 8'hFF);
    rchk(OFS_FLAGS0, 8'hFF);
    wr(OFS_FLAGS0, 8'h81);
    rchk(OFS_FLAGS0, 8'h7E);
    iread(7'h05, 8'h1A);
    wr(OFS_ACC_DATA, 8'h00);
    wr(OFS_ACC_CTRL, 8'h02);
    rchk(OFS_ACC_STAT, 8'h01);
    rchk(OFS_ACC_STAT, 8'h00);
    iread(7'h02, 8'h0A);
    clr();
    send(4'h5, 1'b1);
    iread(7'h01, 8'h15);
    iread(7'h02, 8'h0A);
    rchk(OFS_FLAGS0, 8'hFD);
    $display("t_extract done");
  endtask
  task automatic t_four_irq();
    wr(OFS_SIG_CFG, 8'h00);
    send(4'hA, 1'b0);
    iread(7'h03, 8'h18);
    `CHK("irq", 1'b0, irq)
    wr(OFS_SIG_CFG, 8'h02);
    @(posedge clk_sys);
    #1;
    `CHK("irq", 1'b1, irq)
    clr();
    @(posedge clk_sys);
    #1;
    `CHK("irq", 1'b0, irq)
    $display("t_four_irq done");
  endtask
  task automatic t_hold();
    wr(OFS_SIG_CFG, 8'h09);
    send(4'h5, 1'b0);
    iread(7'h01, 8'h18);
    wr(OFS_SIG_CFG, 8'h05);
    send(4'h3, 1'b0);
    iread(7'h01, 8'h18);
    send(4'h3, 1'b0);
    iread(7'h01, 8'h13);
    wr(OFS_SIG_CFG, 8'h01);
    clr();
    $display("t_hold done");
  endtask
  task automatic t_payload();
    logic [7:0] e;
    int         f;
    for (int p = 0; p < 5; p++) begin
      wr(OFS_PAY_EN, (p == 4) ? 8'h00 : 8'h01);
      wr(OFS_PAY_CFG, (p == 4) ? 8'h01 : 8'(p));
      send(4'h0, 1'b0);
      for (int j = 0; j < 576; j += 25) begin
        f = j / 24;
        e = (p == 4) ? {3'(j % 24), 4'(f + 1), 1'b0} : (p < 2) ? trunk_byte
            : (p == 2) ? MW_ALAW[f % 8] : MW_MULAW[f % 8];
        `CHK($sformatf("data %0d %0d", p, j), e, od[j])
      end
    end
    $display("t_payload done");
  endtask
  task automatic t_sig();
    logic [3:0] e;
    for (int i = 0; i < 4; i++) begin
      cond_en <= (i == 1);
      wr(OFS_PAY_CFG, (i == 1) ? 8'h00 : 8'h40);
      wr(OFS_PAY_EN, (i < 2) ? 8'h01 : (i == 2) ? 8'h07 : 8'h05);
      send(4'h0, 1'b0);
      e = (i < 2) ? cond_code : {4{i == 2}};
      `CHK($sformatf("sig %0d", i), e, os[40])
    end
    $display("t_sig done");
  endtask
  task automatic t_mode();
    rx_fmt <= FMT_SLC96;
    wr(OFS_PAY_EN, 8'h08);
    send(4'hF, 1'b0);
    iread(7'h01, 8'h1C);
    wr(OFS_PAY_CFG, 8'h80);
    wr(OFS_PAY_EN, 8'h01);
    send(4'h0, 1'b0);
    `CHK("snap", 4'hC, os[575])
    rx_fmt <= 2'h3;
    wr(OFS_PAY_EN, 8'h07);
    send(4'h0, 1'b0);
    `CHK("nofix", 4'h0, os[40])
    $display("t_mode done");
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence after six reset cycles
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    t_regs();
    t_extract();
    t_four_irq();
    t_hold();
    t_payload();
    t_sig();
    t_mode();
    final_report();
  end
  // Watchdog, about four times the expected run
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end
endmodule
